// ===== core/radio_cmd.sv
/*
 * Serial command interpreter of the radio: SPI slave, register map,
 * transmit and receive payload FIFOs, status flags and interrupt line.
 * Assumes mode 0 SPI from a master far slower than clk, and a radio
 * engine on clk that pushes received bytes and reports sent packets.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_cmd
	import radio_cmd_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Serial link pins.
	input wire logic spi_clk,
	input wire logic chip_select_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	// Radio engine side.
	input wire logic radio_active,
	input wire logic rx_in_valid,
	input wire logic [7:0] rx_in_byte,
	input wire logic rx_in_last,
	input wire logic [2:0] rx_in_pipe,
	input wire logic [4:0] tx_out_index,
	input wire logic tx_sent,
	input wire logic tx_retry_limit,
	// Registered state for the radio engine.
	output logic radio_irq_n,
	output logic [7:0] config_out,
	output logic [39:0] tx_addr_out,
	output logic [7:0] extension_out,
	output logic tx_ready,
	output logic [7:0] tx_head_byte,
	output logic [5:0] tx_head_len,
	output logic tx_head_noack,
	output logic [2:0] tx_head_pipe
);
	import radio_cmd_pkg::*;

	logic sclk_s, csn_s, mosi_s;
	logic sclk_prev_q, csn_prev_q;
	logic [7:0] shin_q, shin_d, shout_q, shout_d, cmd_q, cmd_d;
	logic [2:0] bit_q, bit_d;
	logic [5:0] byte_q, byte_d;
	logic miso_q, miso_d, wrote_q, wrote_d, irq_n_q, irq_n_d;
	logic [7:0] config_q, config_d, ext_q, ext_d;
	logic [39:0] addr_q, addr_d;
	logic [2:0] flags_q, flags_d, pipe_q, pipe_d;
	logic reuse_q, reuse_d;
	logic [7:0] tx_mem_q [FIFO_LEVELS][PAYLOAD_BYTES];
	logic [7:0] tx_mem_d [FIFO_LEVELS][PAYLOAD_BYTES];
	logic [7:0] rx_mem_q [FIFO_LEVELS][PAYLOAD_BYTES];
	logic [7:0] rx_mem_d [FIFO_LEVELS][PAYLOAD_BYTES];
	logic [5:0] tx_len_q [FIFO_LEVELS], tx_len_d [FIFO_LEVELS];
	logic [5:0] rx_len_q [FIFO_LEVELS], rx_len_d [FIFO_LEVELS];
	logic [2:0] tx_pipe_q [FIFO_LEVELS], tx_pipe_d [FIFO_LEVELS];
	logic [2:0] rx_pipe_q [FIFO_LEVELS], rx_pipe_d [FIFO_LEVELS];
	logic tx_noack_q [FIFO_LEVELS], tx_noack_d [FIFO_LEVELS];
	logic [1:0] tx_cnt_q, tx_cnt_d, tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d;
	logic [1:0] rx_cnt_q, rx_cnt_d, rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d;
	logic [5:0] rx_idx_q, rx_idx_d;
	logic [7:0] head_byte_q;
	logic ready_q, head_noack_q;
	logic [5:0] head_len_q;
	logic [2:0] head_pipe_q;
	logic sclk_rise, sclk_fall, csn_fall, csn_rise, done_v;
	logic [7:0] status_v, fifo_v, byte_v, cmd_v;

	// Pins cross into clk before anything looks at them.
	bit_sync #(.WIDTH(3), .INIT(3'b010)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.level_in({spi_clk, chip_select_n, serial_data_in}),
		.level_out({sclk_s, csn_s, mosi_s})
	);

	// Edges of the synchronised link clock and chip select.
	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;
	assign csn_fall = ~csn_s & csn_prev_q;
	assign csn_rise = csn_s & ~csn_prev_q;
	assign byte_v = {shin_q[6:0], mosi_s};
	assign done_v = ~csn_s & sclk_rise & (bit_q == 3'h7);
	assign status_v = {1'b0, flags_q, pipe_q, tx_cnt_q == LEVELS_FULL};
	assign fifo_v = {1'b0, reuse_q, tx_cnt_q == LEVELS_FULL, tx_cnt_q == 2'h0,
		2'b00, rx_cnt_q == LEVELS_FULL, rx_cnt_q == 2'h0};

	// Advances a FIFO pointer modulo three.
	function automatic logic [1:0] inc3(input logic [1:0] p);
		return (p == 2'h2) ? 2'h0 : p + 2'h1;
	endfunction

	// Byte k of the addressed register as the host sees it.
	function automatic logic [7:0] reg_byte(input logic [4:0] a, input logic [5:0] k);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			ADDR_CONFIG: r = config_q;
			ADDR_STATUS: r = status_v;
			ADDR_TX_ADDR: r = (k < 6'(ADDR_BYTES)) ? addr_q[k[2:0]*8 +: 8] : 8'h00;
			ADDR_FIFO_STATUS: r = fifo_v;
			ADDR_EXTENSION: r = ext_q;
			default: r = 8'h00;
		endcase
		return (k == 6'h00 || a == ADDR_TX_ADDR) ? r : 8'h00;
	endfunction

	// Next values of link, register, FIFO and flag state.
	always_comb begin
		logic [5:0] k;
		logic tx_push, tx_pop, rx_push, rx_pop, tx_fl, rx_fl;
		logic [2:0] set_v, clr_v;
		k = byte_q - 6'h01;
		{tx_push, tx_pop, rx_push, rx_pop, tx_fl, rx_fl} = 6'h00;
		set_v = 3'h0;
		clr_v = 3'h0;
		shin_d = shin_q;
		shout_d = shout_q;
		cmd_d = cmd_q;
		cmd_v = cmd_q;
		bit_d = bit_q;
		byte_d = byte_q;
		miso_d = miso_q;
		wrote_d = wrote_q;
		config_d = config_q;
		ext_d = ext_q;
		addr_d = addr_q;
		reuse_d = reuse_q;
		tx_mem_d = tx_mem_q;
		rx_mem_d = rx_mem_q;
		tx_len_d = tx_len_q;
		rx_len_d = rx_len_q;
		tx_pipe_d = tx_pipe_q;
		rx_pipe_d = rx_pipe_q;
		tx_noack_d = tx_noack_q;
		rx_idx_d = rx_idx_q;
		if (csn_fall) begin
			// Status goes out first; its MSB is on the pin before any edge.
			miso_d = status_v[7];
			shout_d = {status_v[6:0], 1'b0};
			bit_d = 3'h0;
			byte_d = 6'h00;
			cmd_d = IDLE_COMMAND;
			wrote_d = 1'b0;
		end else if (~csn_s && sclk_rise) begin
			shin_d = byte_v;
			bit_d = bit_q + 3'h1;
		end else if (~csn_s && sclk_fall) begin
			miso_d = shout_q[7];
			shout_d = {shout_q[6:0], 1'b0};
		end
		if (done_v && byte_q == 6'h00) begin
			// Command decode; gated extensions fall back to idle.
			cmd_v = byte_v;
			if ((byte_v == RX_WIDTH_READ_CMD && !ext_q[EXT_WIDTH_EN]) ||
				(byte_v[7:3] == CMD_ACK_WRITE_TOP &&
				(!ext_q[EXT_ACK_PL_EN] || byte_v[2:0] > PIPE_LAST_VALID)) ||
				(byte_v == CMD_TX_NOACK && !ext_q[EXT_NOACK_EN])) begin
				cmd_v = IDLE_COMMAND;
			end
			cmd_d = cmd_v;
			if (cmd_v == CMD_TX_FLUSH) begin
				tx_fl = 1'b1;
				reuse_d = 1'b0;
			end
			if (cmd_v == CMD_RX_FLUSH) begin
				rx_fl = 1'b1;
			end
			if (cmd_v == RESEND_LAST_CMD) begin
				reuse_d = 1'b1;
			end
			if (cmd_v == CMD_TX_WRITE || cmd_v == CMD_TX_NOACK) begin
				reuse_d = 1'b0;
			end
		end else if (done_v) begin
			// Data byte k of the current command.
			if (cmd_q[7:5] == CMD_REG_TOP_WR && !radio_active) begin
				case (cmd_q[4:0])
					ADDR_CONFIG: config_d = byte_v;
					ADDR_STATUS: clr_v = byte_v[ST_RX:ST_RT];
					ADDR_TX_ADDR: begin
						if (k < 6'(ADDR_BYTES)) begin
							addr_d[k[2:0]*8 +: 8] = byte_v;
						end
					end
					ADDR_EXTENSION: ext_d = byte_v;
					default: ;
				endcase
			end
			if ((cmd_q == CMD_TX_WRITE || cmd_q == CMD_TX_NOACK ||
				cmd_q[7:3] == CMD_ACK_WRITE_TOP) && tx_cnt_q != LEVELS_FULL &&
				k < 6'(PAYLOAD_BYTES)) begin
				tx_mem_d[tx_wr_q][k[4:0]] = byte_v;
				tx_len_d[tx_wr_q] = k + 6'h01;
				tx_noack_d[tx_wr_q] = (cmd_q == CMD_TX_NOACK);
				tx_pipe_d[tx_wr_q] = cmd_q[2:0];
				wrote_d = 1'b1;
			end
		end
		if (done_v) begin
			// Prepare data byte byte_q for the master to clock out.
			if (cmd_v[7:5] == CMD_REG_TOP_RD) begin
				shout_d = reg_byte(cmd_v[4:0], byte_q);
			end else if (cmd_v == CMD_RX_READ && rx_cnt_q != 2'h0) begin
				shout_d = (byte_q < 6'(PAYLOAD_BYTES)) ?
					rx_mem_q[rx_rd_q][byte_q[4:0]] : 8'h00;
			end else if (cmd_v == RX_WIDTH_READ_CMD && byte_q == 6'h00) begin
				shout_d = {2'b00, rx_len_q[rx_rd_q]};
			end else begin
				shout_d = 8'h00;
			end
			byte_d = (byte_q == 6'h3F) ? byte_q : byte_q + 6'h01;
		end
		if (csn_rise) begin
			// Frame end commits a written payload or drops a read one.
			tx_push = wrote_q;
			rx_pop = (cmd_q == CMD_RX_READ) && byte_q > 6'h01 && rx_cnt_q != 2'h0;
			wrote_d = 1'b0;
		end
		if (tx_sent) begin
			set_v[1] = 1'b1;
			tx_pop = (tx_cnt_q != 2'h0) && !reuse_q;
		end
		if (tx_retry_limit) begin
			set_v[0] = 1'b1;
		end
		if (rx_in_valid) begin
			if (rx_cnt_q != LEVELS_FULL && rx_idx_q < 6'(PAYLOAD_BYTES)) begin
				rx_mem_d[rx_wr_q][rx_idx_q[4:0]] = rx_in_byte;
			end
			rx_idx_d = (rx_idx_q == 6'h3F) ? rx_idx_q : rx_idx_q + 6'h01;
			if (rx_in_last) begin
				rx_idx_d = 6'h00;
				rx_push = (rx_cnt_q != LEVELS_FULL);
				rx_len_d[rx_wr_q] = rx_idx_q + 6'h01;
				rx_pipe_d[rx_wr_q] = rx_in_pipe;
				set_v[2] = rx_push;
			end
		end
		// Pointer and level bookkeeping; flushes override.
		tx_wr_d = tx_push ? inc3(tx_wr_q) : tx_wr_q;
		tx_rd_d = tx_pop ? inc3(tx_rd_q) : tx_rd_q;
		tx_cnt_d = tx_cnt_q + {1'b0, tx_push} - {1'b0, tx_pop};
		rx_wr_d = rx_push ? inc3(rx_wr_q) : rx_wr_q;
		rx_rd_d = rx_pop ? inc3(rx_rd_q) : rx_rd_q;
		rx_cnt_d = rx_cnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
		if (tx_fl) begin
			{tx_wr_d, tx_rd_d, tx_cnt_d} = 6'h00;
		end
		if (rx_fl) begin
			{rx_wr_d, rx_rd_d, rx_cnt_d} = 6'h00;
		end
		// A flag set in the same cycle as its clear stays set.
		flags_d = (flags_q & ~clr_v) | set_v;
		irq_n_d = ~|(flags_d & ~{config_q[CFG_MASK_RX], config_q[CFG_MASK_TX],
			config_q[CFG_MASK_RT]});
		pipe_d = pipe_q;
		if (irq_n_q && !irq_n_d) begin
			pipe_d = (rx_cnt_d != 2'h0) ? rx_pipe_d[rx_rd_d] : PIPE_NONE;
		end
	end

	// Registers all state but payload storage and slot attributes, which carry no reset.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_q <= 1'b0;
			csn_prev_q <= 1'b1;
			{shin_q, shout_q} <= 16'h0000;
			cmd_q <= IDLE_COMMAND;
			bit_q <= 3'h0;
			byte_q <= 6'h00;
			{miso_q, wrote_q, reuse_q} <= 3'h0;
			irq_n_q <= 1'b1;
			config_q <= CONFIG_RESET;
			ext_q <= EXTENSION_RESET;
			addr_q <= TX_ADDR_RESET;
			flags_q <= 3'h0;
			pipe_q <= PIPE_NONE;
			{tx_cnt_q, tx_wr_q, tx_rd_q, rx_cnt_q, rx_wr_q, rx_rd_q} <= 12'h000;
			rx_idx_q <= 6'h00;
			head_byte_q <= 8'h00;
			{ready_q, head_len_q, head_noack_q, head_pipe_q} <= 11'h000;
		end else begin
			sclk_prev_q <= sclk_s;
			csn_prev_q <= csn_s;
			{shin_q, shout_q, cmd_q, bit_q, byte_q} <= {shin_d, shout_d, cmd_d, bit_d, byte_d};
			{miso_q, wrote_q, reuse_q, irq_n_q} <= {miso_d, wrote_d, reuse_d, irq_n_d};
			{config_q, ext_q, addr_q} <= {config_d, ext_d, addr_d};
			{flags_q, pipe_q} <= {flags_d, pipe_d};
			{tx_cnt_q, tx_wr_q, tx_rd_q} <= {tx_cnt_d, tx_wr_d, tx_rd_d};
			{rx_cnt_q, rx_wr_q, rx_rd_q} <= {rx_cnt_d, rx_wr_d, rx_rd_d};
			rx_idx_q <= rx_idx_d;
			head_byte_q <= tx_mem_q[tx_rd_q][tx_out_index];
			ready_q <= (tx_cnt_q != 2'h0);
			head_len_q <= tx_len_q[tx_rd_q];
			head_noack_q <= tx_noack_q[tx_rd_q];
			head_pipe_q <= tx_pipe_q[tx_rd_q];
		end
	end

	// Payload storage and per-slot attributes.
	always_ff @(posedge clk) begin
		tx_mem_q <= tx_mem_d;
		rx_mem_q <= rx_mem_d;
		tx_len_q <= tx_len_d;
		rx_len_q <= rx_len_d;
		tx_pipe_q <= tx_pipe_d;
		rx_pipe_q <= rx_pipe_d;
		tx_noack_q <= tx_noack_d;
	end

	// Outputs come straight from flip-flops.
	assign serial_data_out = miso_q;
	assign radio_irq_n = irq_n_q;
	assign config_out = config_q;
	assign tx_addr_out = addr_q;
	assign extension_out = ext_q;
	assign tx_ready = ready_q;
	assign tx_head_byte = head_byte_q;
	assign tx_head_len = head_len_q;
	assign tx_head_noack = head_noack_q;
	assign tx_head_pipe = head_pipe_q;

	// A receive read frame: command, at least one data byte, then chip select rises.
	sequence s_rx_read_end;
		(cmd_q == CMD_RX_READ && byte_q > 6'h01 && rx_cnt_q != 2'h0 && !rx_in_valid) ##0 csn_rise;
	endsequence

	a_status_first: assert property (@(posedge clk) disable iff (!reset_n)
		csn_fall |=> serial_data_out == $past(status_v[7]))
		else $error("status MSB not presented after chip select fell");
	a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
		##1 radio_irq_n == !(|(flags_q & ~{$past(config_q[CFG_MASK_RX]),
		$past(config_q[CFG_MASK_TX]), $past(config_q[CFG_MASK_RT])})))
		else $error("interrupt line disagrees with unmasked flags");
	a_tx_flush: assert property (@(posedge clk) disable iff (!reset_n)
		(done_v && byte_q == 6'h00 && byte_v == CMD_TX_FLUSH) |=> tx_cnt_q == 2'h0 && !reuse_q)
		else $error("transmit flush left payloads or reuse");
	a_rx_flush: assert property (@(posedge clk) disable iff (!reset_n)
		(done_v && byte_q == 6'h00 && byte_v == CMD_RX_FLUSH) |=> rx_cnt_q == 2'h0)
		else $error("receive flush left payloads");
	a_reuse_set: assert property (@(posedge clk) disable iff (!reset_n)
		(done_v && byte_q == 6'h00 && byte_v == RESEND_LAST_CMD) |=> reuse_q)
		else $error("resend command did not set reuse");
	a_width_gate: assert property (@(posedge clk) disable iff (!reset_n)
		(done_v && byte_q == 6'h00 && byte_v == RX_WIDTH_READ_CMD && !ext_q[EXT_WIDTH_EN])
		|=> cmd_q == IDLE_COMMAND)
		else $error("width read accepted while disabled");
	a_retry_keep: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_retry_limit && !tx_sent && !csn_rise && !done_v)
		|=> tx_cnt_q == $past(tx_cnt_q) && flags_q[0])
		else $error("retry limit lost the payload or flag");
	a_rx_pop: assert property (@(posedge clk) disable iff (!reset_n)
		s_rx_read_end |=> rx_cnt_q == $past(rx_cnt_q) - 2'h1)
		else $error("read payload not removed at frame end");
	a_pipe_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(radio_irq_n == 1'b0 || $past(radio_irq_n) == 1'b1 && radio_irq_n) |=> $stable(pipe_q)
		or $fell(radio_irq_n))
		else $error("pipe field changed outside an interrupt fall");
endmodule
`default_nettype wire

// ===== core/radio_cmd_pkg.sv
/*
 * Constants of the radio command interpreter: command words, register
 * addresses, field positions and reset values.
 * Assumes nothing of its surroundings; imported by radio_cmd and its bench.
 */
package radio_cmd_pkg;
	// Command words.
	localparam logic [7:0] CMD_RD_REG_BASE = 8'h00;
	localparam logic [7:0] CMD_WR_REG_BASE = 8'h20;
	localparam logic [2:0] CMD_REG_TOP_RD = 3'h0;
	localparam logic [2:0] CMD_REG_TOP_WR = 3'h1;
	localparam logic [7:0] CMD_RX_READ = 8'h61;
	localparam logic [7:0] CMD_TX_WRITE = 8'hA0;
	localparam logic [7:0] CMD_TX_FLUSH = 8'hE1;
	localparam logic [7:0] CMD_RX_FLUSH = 8'hE2;
	localparam logic [7:0] RESEND_LAST_CMD = 8'hE3;
	localparam logic [7:0] RX_WIDTH_READ_CMD = 8'h60;
	localparam logic [4:0] CMD_ACK_WRITE_TOP = 5'h15;
	localparam logic [2:0] PIPE_LAST_VALID = 3'h5;
	localparam logic [7:0] CMD_TX_NOACK = 8'hB0;
	localparam logic [7:0] IDLE_COMMAND = 8'hFF;
	// Register map addresses.
	localparam logic [4:0] ADDR_CONFIG = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h07;
	localparam logic [4:0] ADDR_TX_ADDR = 5'h10;
	localparam logic [4:0] ADDR_FIFO_STATUS = 5'h17;
	localparam logic [4:0] ADDR_EXTENSION = 5'h1D;
	// Configuration fields.
	localparam int CFG_MASK_RX = 6;
	localparam int CFG_MASK_TX = 5;
	localparam int CFG_MASK_RT = 4;
	localparam int CFG_PWR_UP = 1;
	localparam int CFG_PRIM_RX = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h08;
	// Extension enable fields.
	localparam int EXT_WIDTH_EN = 2;
	localparam int EXT_ACK_PL_EN = 1;
	localparam int EXT_NOACK_EN = 0;
	localparam logic [7:0] EXTENSION_RESET = 8'h00;
	// Status fields; flags are ordered {received, sent, retry limit}.
	localparam int ST_RX = 6;
	localparam int ST_TX = 5;
	localparam int ST_RT = 4;
	localparam logic [2:0] PIPE_NONE = 3'h7;
	// FIFO status fields.
	localparam int FS_REUSE = 6;
	localparam int FS_TX_FULL = 5;
	localparam int FS_TX_EMPTY = 4;
	localparam int FS_RX_FULL = 1;
	localparam int FS_RX_EMPTY = 0;
	// Sizes.
	localparam int FIFO_LEVELS = 3;
	localparam int PAYLOAD_BYTES = 32;
	localparam int ADDR_BYTES = 5;
	localparam logic [39:0] TX_ADDR_RESET = 40'h00_0000_0000;
	localparam logic [1:0] LEVELS_FULL = 2'h3;
endpackage

// ===== core/bit_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level from another clock domain or a pin.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Level in and synchronised level out.
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Only the second stage is visible to the rest of the block.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= level_in;
			sync_q <= meta_q;
		end
	end

	assign level_out = sync_q;
endmodule
`default_nettype wire

// ===== verification/spi_host_model.sv
/*
 * Behavioural serial master for the radio command interpreter: frames
 * commands with chip select, shifts bytes out and captures the answers.
 * Assumes mode 0 timing and a slave clock far faster than the link.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Serial link pins.
	output logic spi_clk,
	output logic chip_select_n,
	output logic serial_data_in,
	input wire logic serial_data_out,
	// Captured answer byte and a toggle per byte.
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	// The link clock stands still low and select stays high between frames.
	initial begin
		spi_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end

	// Sends n bytes in one frame; each byte goes MSB first.
	task automatic run(input int n, input logic [7:0] b [0:33]);
		logic [7:0] r;
		chip_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				serial_data_in = b[i][j];
				#62.5 spi_clk = 1'b1;
				r[j] = serial_data_out;
				#62.5 spi_clk = 1'b0;
			end
			rx_byte = r;
			rx_stb = ~rx_stb;
		end
		#62.5 chip_select_n = 1'b1;
		// A released data line must not keep showing its last bit.
		serial_data_in = ~serial_data_in;
		#200;
	endtask
endmodule
`default_nettype wire

// ===== verification/radio_cmd_tb.sv
/*
 * Self-checking bench for the radio command interpreter: register,
 * payload, flush, reuse, interrupt and receive paths over the link.
 * Assumes the serial host model and the design package are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_cmd_tb;
	import radio_cmd_pkg::*;
	logic clk, reset_n, radio_active, rx_in_valid, rx_in_last, tx_sent, tx_retry_limit;
	logic [7:0] rx_in_byte, config_out, extension_out, tx_head_byte, rx_byte;
	logic [2:0] rx_in_pipe, tx_head_pipe;
	logic [4:0] tx_out_index;
	logic [5:0] tx_head_len;
	logic [39:0] tx_addr_out;
	logic spi_clk, chip_select_n, serial_data_in, serial_data_out;
	logic radio_irq_n, tx_ready, tx_head_noack, rx_stb;
	logic [7:0] tx_b [0:33];
	logic [7:0] ex_b [0:33];
	logic [7:0] ex_m [0:33];
	logic [7:0] rx_d [0:31];
	logic [15:0] exp_q[$];
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int len;

	radio_cmd radio_cmd_i (.clk(clk), .reset_n(reset_n), .spi_clk(spi_clk),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .radio_active(radio_active),
		.rx_in_valid(rx_in_valid), .rx_in_byte(rx_in_byte), .rx_in_last(rx_in_last),
		.rx_in_pipe(rx_in_pipe), .tx_out_index(tx_out_index), .tx_sent(tx_sent),
		.tx_retry_limit(tx_retry_limit), .radio_irq_n(radio_irq_n),
		.config_out(config_out), .tx_addr_out(tx_addr_out),
		.extension_out(extension_out), .tx_ready(tx_ready), .tx_head_byte(tx_head_byte),
		.tx_head_len(tx_head_len), .tx_head_noack(tx_head_noack),
		.tx_head_pipe(tx_head_pipe));
	spi_host_model spi_host_model_i (.spi_clk(spi_clk), .chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.rx_byte(rx_byte), .rx_stb(rx_stb));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Counts, prints the verdict and ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Each answered byte with a nonzero mask is compared with the oldest expectation noted; the watch
	// starts after time zero so that the model's first value is not taken as a byte.
	initial begin
		#1;
		forever begin
			@(rx_stb);
			if (exp_q.size() == 0) begin
				chk("unexpected link byte", 64'h0, 64'h1);
			end else if (exp_q[0][15:8] != 8'h00) begin
				chk("link byte", exp_q[0][7:0], rx_byte & exp_q[0][15:8]);
			end
			if (exp_q.size() != 0) begin
				void'(exp_q.pop_front());
			end
		end
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// Lets a few clocks pass so that registered outputs settle.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	// One frame: command, n data bytes, status and noted data expected.
	task automatic op(input logic [7:0] c, input int n, input logic [7:0] st);
		tx_b[0] = c;
		ex_b[0] = st;
		ex_m[0] = 8'hFF;
		for (int k = 0; k <= n; k++) begin
			exp_q.push_back({ex_m[k] & {8{ex_m[k] != 8'h00}}, ex_b[k] & ex_m[k]});
		end
		spi_host_model_i.run(n + 1, tx_b);
		for (int k = 0; k < 34; k++) begin
			ex_m[k] = 8'h00;
		end
		settle();
	endtask

	// One-byte write frame.
	task automatic w1(input logic [7:0] c, input logic [7:0] d, input logic [7:0] st);
		tx_b[1] = d;
		op(c, 1, st);
	endtask

	// Expects a read of n bytes whose values stand in ex_b.
	task automatic rd(input logic [7:0] c, input int n, input logic [7:0] st);
		for (int k = 1; k <= n; k++) begin
			ex_m[k] = 8'hFF;
		end
		op(c, n, st);
	endtask

	// One-cycle radio event pulse: retry limit when r is set, else sent.
	task automatic pulse(input logic r);
		@(posedge clk) #1;
		tx_retry_limit = r;
		tx_sent = ~r;
		@(posedge clk) #1;
		tx_retry_limit = 1'b0;
		tx_sent = 1'b0;
		settle();
	endtask

	// Pushes a received payload of n random bytes on pipe p.
	task automatic rxp(input int n, input logic [2:0] p);
		for (int k = 0; k < n; k++) begin
			@(posedge clk) #1;
			rx_in_valid = 1'b1;
			rx_in_byte = 8'($urandom);
			rx_in_last = (k == n - 1);
			rx_in_pipe = p;
			rx_d[k] = rx_in_byte;
		end
		@(posedge clk) #1;
		rx_in_valid = 1'b0;
		rx_in_last = 1'b0;
		settle();
	endtask

	// Main sequence.
	initial begin
		{radio_active, rx_in_valid, rx_in_last, tx_sent, tx_retry_limit} = '0;
		rx_in_byte = 8'h00;
		rx_in_pipe = 3'h0;
		tx_out_index = 5'h00;
		for (int k = 0; k < 34; k++) begin
			tx_b[k] = 8'h00;
			ex_b[k] = 8'h00;
			ex_m[k] = 8'h00;
		end
		reset_n = 1'b0;
		void'($urandom(17));
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		settle();
		chk("config_out", CONFIG_RESET, config_out);
		chk("extension_out", 8'h00, extension_out);
		chk("radio_irq_n", 1'b1, radio_irq_n);
		chk("tx_ready", 1'b0, tx_ready);
		op(IDLE_COMMAND, 0, 8'h0E);
		$display("done: reset and idle");
		w1(8'h20, 8'h10, 8'h0E);
		ex_b[1] = 8'h10;
		rd(8'h00, 1, 8'h0E);
		radio_active = 1'b1;
		w1(8'h20, 8'h00, 8'h0E);
		radio_active = 1'b0;
		chk("config_out", 8'h10, config_out);
		$display("done: register access");
		for (int k = 1; k <= 5; k++) begin
			tx_b[k] = 8'(k * 8'h11);
		end
		op(8'h30, 5, 8'h0E);
		w1(8'h30, 8'hAA, 8'h0E);
		ex_b[1] = 8'hAA;
		for (int k = 2; k <= 5; k++) begin
			ex_b[k] = 8'(k * 8'h11);
		end
		rd(8'h10, 5, 8'h0E);
		chk("tx_addr_out", 40'h55_4433_22AA, tx_addr_out);
		$display("done: partial write");
		// Width read while its enable bit is clear acts as idle and returns zero.
		ex_b[1] = 8'h00;
		rd(RX_WIDTH_READ_CMD, 1, 8'h0E);
		$display("done: gated width read");
		w1(8'h3D, 8'h07, 8'h0E);
		chk("extension_out", 8'h07, extension_out);
		for (int p = 0; p < FIFO_LEVELS; p++) begin
			len = $urandom_range(PAYLOAD_BYTES, 1);
			for (int k = 1; k <= len; k++) begin
				tx_b[k] = 8'($urandom);
			end
			op(CMD_TX_WRITE, len, 8'h0E);
			if (p == 0) begin
				tx_out_index = 5'($urandom_range(len - 1, 0));
				settle();
				chk("tx_head_len", 6'(len), tx_head_len);
				chk("tx_head_byte", tx_b[tx_out_index + 1], tx_head_byte);
				chk("tx_ready", 1'b1, tx_ready);
			end
		end
		w1(CMD_TX_WRITE, 8'h5A, 8'h0F);
		ex_b[1] = 8'h21;
		rd(8'h17, 1, 8'h0F);
		op(RESEND_LAST_CMD, 0, 8'h0F);
		ex_b[1] = 8'h61;
		rd(8'h17, 1, 8'h0F);
		pulse(1'b1);
		chk("radio_irq_n", 1'b1, radio_irq_n);
		chk("tx_ready", 1'b1, tx_ready);
		op(IDLE_COMMAND, 0, 8'h1F);
		w1(8'h20, 8'h00, 8'h1F);
		chk("radio_irq_n", 1'b0, radio_irq_n);
		w1(8'h27, 8'h10, 8'h1F);
		chk("radio_irq_n", 1'b1, radio_irq_n);
		op(CMD_TX_FLUSH, 0, 8'h0F);
		ex_b[1] = 8'h11;
		rd(8'h17, 1, 8'h0E);
		chk("tx_ready", 1'b0, tx_ready);
		$display("done: transmit fifo and interrupt");
		tx_b[2] = 8'h3C;
		op(8'hAD, 2, 8'h0E);
		chk("tx_head_pipe", 3'h5, tx_head_pipe);
		chk("tx_head_len", 6'h02, tx_head_len);
		op(CMD_TX_FLUSH, 0, 8'h0E);
		w1(8'hAE, 8'h01, 8'h0E);
		chk("tx_ready", 1'b0, tx_ready);
		w1(CMD_TX_NOACK, 8'h02, 8'h0E);
		chk("tx_head_noack", 1'b1, tx_head_noack);
		pulse(1'b0);
		chk("radio_irq_n", 1'b0, radio_irq_n);
		chk("tx_ready", 1'b0, tx_ready);
		op(IDLE_COMMAND, 0, 8'h2E);
		w1(8'h27, 8'h20, 8'h2E);
		chk("radio_irq_n", 1'b1, radio_irq_n);
		$display("done: ack and no-ack payloads");
		rxp(4, 3'h3);
		chk("radio_irq_n", 1'b0, radio_irq_n);
		ex_b[1] = 8'h04;
		rd(RX_WIDTH_READ_CMD, 1, 8'h46);
		for (int k = 0; k < 4; k++) begin
			ex_b[k + 1] = rx_d[k];
		end
		rd(CMD_RX_READ, 4, 8'h46);
		ex_b[1] = 8'h11;
		rd(8'h17, 1, 8'h46);
		w1(8'h27, 8'h40, 8'h46);
		chk("radio_irq_n", 1'b1, radio_irq_n);
		rxp(2, 3'h1);
		op(CMD_RX_FLUSH, 0, 8'h42);
		ex_b[1] = 8'h11;
		rd(8'h17, 1, 8'h42);
		$display("done: receive path");
		tally_and_finish();
	end
endmodule
`default_nettype wire
